// File: design/asf_pkg.sv
// package: constants and carriers of the audio fifo and dma event block
package asf_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int ASF_WORD_W = 32;
  localparam int ASF_FIFO_DEPTH = 64;
  localparam int ASF_THR_W = 8;
  localparam int ASF_LVL_W = 7;
  localparam int ASF_PEND_W = 7;

  // ---------------------------------------------------------------
  // control word field positions
  // ---------------------------------------------------------------
  localparam int ASF_THR_LSB = 8;
  localparam int ASF_THR_MSB = 15;
  localparam int ASF_ENA_BIT = 16;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic ASF_EVENT_RST = 1'h0;
  localparam logic ASF_ERR_RST = 1'h0;
  localparam int ASF_SET_CLR_WINDOW = 2;

  // control word as seen by the block
  typedef struct packed {
    logic [14:0] rsvdHi;
    logic enable;
    logic [ASF_THR_MSB-ASF_THR_LSB:0] threshold;
    logic [ASF_THR_LSB-1:0] rsvdLo;
  } asf_ctrl_type;

  // per-direction status
  typedef struct packed {
    logic eventLevel;
    logic fault;
    logic [ASF_LVL_W-1:0] level;
  } asf_stat_type;

  // zero threshold behaves as one word
  function automatic logic [ASF_THR_W-1:0] asf_eff_thr(
    input logic [ASF_THR_W-1:0] thr
  );
    asf_eff_thr = (thr == 8'h00) ? 8'h01 : thr;
  endfunction : asf_eff_thr

endpackage : asf_pkg

// File: design/asf_fifo.sv
// data buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module asf_fifo
  import asf_pkg::*;
#(
  parameter int WIDTH = ASF_WORD_W,
  parameter int DEPTH = ASF_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [PW:0] count_r;
  wire logic push;
  wire logic pop;

  // handshakes
  assign inReady = (count_r != (PW+1)'(DEPTH)) && !flush;
  assign outValid = (count_r != '0) && !flush;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr_r];
  assign level = count_r;

  // storage
  always_ff @(posedge clk) begin
    if (push) mem[wrPtr_r] <= inData;
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wrPtr_r <= (wrPtr_r == PW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      if (pop) rdPtr_r <= (rdPtr_r == PW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : asf_fifo
`default_nettype wire

// File: design/asf_event_gen.sv
// one direction's level transfer request toward the dma
`timescale 1ns/1ps
`default_nettype none
module asf_event_gen
  import asf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  input wire logic [ASF_THR_W-1:0] threshold,
  // word movements
  input wire logic pinMove,
  input wire logic dmaMove,
  // request level
  output logic eventLevel
);
  logic [ASF_THR_W-1:0] pinCnt_r;
  logic [ASF_THR_W-1:0] dmaCnt_r;
  logic [ASF_PEND_W-1:0] pend_r;
  logic [ASF_PEND_W-1:0] pend_nxt;
  wire logic [ASF_THR_W-1:0] thrEff;
  wire logic setPulse;
  wire logic clrPulse;

  // threshold hits on each side
  assign thrEff = asf_eff_thr(threshold);
  assign setPulse = pinMove && (pinCnt_r == thrEff - 8'h01); // R04
  assign clrPulse = dmaMove && (dmaCnt_r == thrEff - 8'h01); // R03

  // pending count: a coinciding set and clear cancel, never drop the set
  always_comb begin
    pend_nxt = pend_r;
    if (setPulse && !clrPulse && pend_r != '1) pend_nxt = pend_r + 1'b1;
    // a clear with nothing pending must not eat a coinciding set
    if (setPulse && clrPulse && pend_r == '0) pend_nxt = 7'h01;
    if (clrPulse && !setPulse && pend_r != '0) pend_nxt = pend_r - 1'b1;
  end // R06

  // word counters and request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinCnt_r <= '0;
      dmaCnt_r <= '0;
      pend_r <= '0;
      eventLevel <= ASF_EVENT_RST; // R11
    end else if (!enable) begin
      pinCnt_r <= '0;
      dmaCnt_r <= '0;
      pend_r <= '0;
      eventLevel <= ASF_EVENT_RST;
    end else begin
      if (pinMove) pinCnt_r <= setPulse ? '0 : pinCnt_r + 8'h01;
      if (dmaMove) dmaCnt_r <= clrPulse ? '0 : dmaCnt_r + 8'h01;
      pend_r <= pend_nxt;
      eventLevel <= (pend_nxt != '0); // R02
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  setWins_a: assert property ( // R06
    enable && setPulse |=> eventLevel)
    else $error("set lost against a clear");
  clearLast_a: assert property ( // R03
    enable && clrPulse && !setPulse && pend_r == 7'h01 |=> !eventLevel)
    else $error("request not cleared after threshold reads");
  holdLevel_a: assert property ( // R02
    enable && eventLevel && !clrPulse ##1 enable |-> eventLevel)
    else $error("request dropped without a clear");
  offIdle_a: assert property ( // R11
    !enable |=> !eventLevel && pinCnt_r == 8'h00)
    else $error("request active while disabled");

endmodule : asf_event_gen
`default_nettype wire

// File: design/asf_audio_fifo_dma.sv
// audio serial port data buffers and dma synchronisation events
`timescale 1ns/1ps
`default_nettype none

// How it works
// (R01) Each direction, receive and transmit, has its own request to the dma.
// (R02) A request is a level that stays high until its clear condition.
// (R03) A request clears after the dma moves a threshold of words.
// (R04) A request sets each time a threshold of words moves on the pins.
// (R05) Thresholds come from bits 15:8 of the rx and tx fifo control words.
// (R06) A set that meets a clear in the same cycle leaves the request high.
// (R07) A missed request shows as rx overflow or tx underflow for software.
// (R08) Each data buffer holds 64 words.
// (R09) Software picks thresholds as serializer multiples up to 32 words.
// (R10) The dma keeps its service latency short for these transfers.
// (R11) Requests are low in reset; each direction is evaluated on its own.
module asf_audio_fifo_dma
  import asf_pkg::*;
#(
  parameter int WIDTH = ASF_WORD_W,
  parameter int DEPTH = ASF_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control words
  input wire asf_ctrl_type rxFifoControl,
  input wire asf_ctrl_type txFifoControl,
  input wire logic errClear,
  // receive, serializer side
  input wire logic rxPinValid,
  output logic rxPinReady,
  input wire logic [WIDTH-1:0] rxPinData,
  // receive, dma side
  output logic rxDmaValid,
  input wire logic rxDmaReady,
  output logic [WIDTH-1:0] rxDmaData,
  // transmit, dma side
  input wire logic txDmaValid,
  output logic txDmaReady,
  input wire logic [WIDTH-1:0] txDmaData,
  // transmit, serializer side
  input wire logic txPinTake,
  output logic txPinValid,
  output logic [WIDTH-1:0] txPinData,
  // dma synchronisation events
  output logic rxDmaEvent,
  output logic txDmaEvent,
  // status
  output asf_stat_type rxStat,
  output asf_stat_type txStat
);

  // ---------------------------------------------------------------
  // control decode
  // ---------------------------------------------------------------
  wire logic rxEnable;
  wire logic txEnable;
  wire logic [ASF_THR_W-1:0] rxThreshold;
  wire logic [ASF_THR_W-1:0] txThreshold;

  // thresholds and enables from the control words
  assign rxEnable = rxFifoControl.enable;
  assign txEnable = txFifoControl.enable;
  assign rxThreshold = rxFifoControl.threshold; // R05
  assign txThreshold = txFifoControl.threshold; // R05

  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  wire logic rxInReady;
  wire logic rxOutValid;
  wire logic [$clog2(DEPTH):0] rxLevel;
  wire logic rxPinMove;
  wire logic rxDmaMove;
  wire logic rxOverEvt;
  logic rxOverflow_r;
  logic rxOverflow_nxt;

  // receive buffer, serializers fill and dma drains
  asf_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) rxFifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(!rxEnable),
    .inValid(rxPinValid),
    .inReady(rxInReady),
    .inData(rxPinData),
    .outValid(rxOutValid),
    .outReady(rxDmaReady),
    .outData(rxDmaData),
    .level(rxLevel)
  ); // R08

  // receive word movements and overflow
  assign rxPinReady = rxInReady;
  assign rxDmaValid = rxOutValid;
  assign rxPinMove = rxPinValid && rxInReady;
  assign rxDmaMove = rxOutValid && rxDmaReady;
  assign rxOverEvt = rxEnable && rxPinValid && !rxInReady; // R07

  // receive request generator
  asf_event_gen rxEvt (
    .clk(clk),
    .rst_n(rst_n),
    .enable(rxEnable),
    .threshold(rxThreshold),
    .pinMove(rxPinMove),
    .dmaMove(rxDmaMove),
    .eventLevel(rxDmaEvent)
  ); // R01

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  wire logic txOutValid;
  wire logic [$clog2(DEPTH):0] txLevel;
  wire logic txPinMove;
  wire logic txDmaMove;
  wire logic txUnderEvt;
  logic txUnderflow_r;
  logic txUnderflow_nxt;

  // transmit buffer, dma fills and serializers drain
  asf_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) txFifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(!txEnable),
    .inValid(txDmaValid),
    .inReady(txDmaReady),
    .inData(txDmaData),
    .outValid(txOutValid),
    .outReady(txPinTake),
    .outData(txPinData),
    .level(txLevel)
  ); // R08

  // transmit word movements and underflow
  assign txPinValid = txOutValid;
  assign txPinMove = txPinTake && txOutValid;
  assign txDmaMove = txDmaValid && txDmaReady;
  assign txUnderEvt = txEnable && txPinTake && !txOutValid; // R07

  // transmit request generator
  asf_event_gen txEvt (
    .clk(clk),
    .rst_n(rst_n),
    .enable(txEnable),
    .threshold(txThreshold),
    .pinMove(txPinMove),
    .dmaMove(txDmaMove),
    .eventLevel(txDmaEvent)
  ); // R01

  // ---------------------------------------------------------------
  // error flags
  // ---------------------------------------------------------------
  // sticky until software clears; a new error beats the clear
  always_comb begin
    rxOverflow_nxt = rxOverflow_r;
    txUnderflow_nxt = txUnderflow_r;
    if (errClear) rxOverflow_nxt = 1'h0;
    if (errClear) txUnderflow_nxt = 1'h0;
    if (rxOverEvt) rxOverflow_nxt = 1'h1; // R07
    if (txUnderEvt) txUnderflow_nxt = 1'h1; // R07
  end

  // flag registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxOverflow_r <= ASF_ERR_RST;
      txUnderflow_r <= ASF_ERR_RST;
    end else begin
      rxOverflow_r <= rxOverflow_nxt;
      txUnderflow_r <= txUnderflow_nxt;
    end
  end

  // ---------------------------------------------------------------
  // status
  // ---------------------------------------------------------------
  // status words gather request, fault and fill level
  assign rxStat.eventLevel = rxDmaEvent;
  assign rxStat.fault = rxOverflow_r;
  assign rxStat.level = ASF_LVL_W'(rxLevel);
  assign txStat.eventLevel = txDmaEvent;
  assign txStat.fault = txUnderflow_r;
  assign txStat.level = ASF_LVL_W'(txLevel);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // helper: pin-side words while the rx request is low, since its last fall
  logic [ASF_THR_W:0] rxSinceRise_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSinceRise_r <= '0;
    end else if (!rxEnable || rxDmaEvent) begin
      rxSinceRise_r <= '0;
    end else if (rxPinMove && rxSinceRise_r != '1) begin
      rxSinceRise_r <= rxSinceRise_r + 9'h001;
    end
  end

  rxOverflow_a: assert property ( // R07
    rxEnable && rxPinValid && !rxPinReady |=> rxStat.fault)
    else $error("rx overflow not flagged");

  txUnderflow_a: assert property ( // R07
    txEnable && txPinTake && !txPinValid |=> txStat.fault)
    else $error("tx underflow not flagged");

  faultClear_a: assert property ( // R07
    errClear && !rxOverEvt ##1 !rxOverEvt |-> !rxStat.fault)
    else $error("rx fault survives its clear");

  rxDepth_a: assert property ( // R08
    rxLevel == (ASF_LVL_W)'(DEPTH) |-> !rxPinReady)
    else $error("rx buffer accepts past its depth");

  txDepth_a: assert property ( // R08
    txLevel <= (ASF_LVL_W)'(DEPTH) && (txLevel != '0 || !txPinValid))
    else $error("tx buffer level out of range");

  rxThreshold_a: assert property ( // R04
    rxEnable && !rxDmaEvent
      && rxSinceRise_r >= {1'h0, asf_eff_thr(rxThreshold)}
      |-> $past(rxFifoControl) != rxFifoControl || !rxEnable)
    else $error("rx request missing after threshold words");

  resetQuiet_a: assert property ( // R11
    $rose(rst_n) |-> !rxDmaEvent && !txDmaEvent)
    else $error("request high out of reset");

  rxSetWins_a: assert property ( // R06
    rxEnable && rxDmaEvent && rxPinMove && rxDmaMove
      && rxThreshold == 8'h01 ##1 rxEnable |-> rxDmaEvent)
    else $error("rx request lost on set and clear");

  separateDir_a: assert property ( // R11
    !txEnable && rxEnable |=> !txDmaEvent)
    else $error("tx request follows rx activity");

  enableOff_a: assert property ( // R01
    !rxEnable |-> !rxPinReady ##1 (!rxDmaEvent && !rxDmaValid))
    else $error("rx path active while disabled");

endmodule : asf_audio_fifo_dma
`default_nettype wire

// File: sim/asf_dma_model.sv
// dma partner: serves rx and tx transfer requests in bursts
`timescale 1ns/1ps
`default_nettype none
module asf_dma_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench control
  input wire logic [7:0] rxThr,
  input wire logic [7:0] txThr,
  input wire logic [7:0] prime,
  input wire logic hold,
  // receive side
  input wire logic rxEvent,
  input wire logic rxValid,
  output logic rxReady,
  // transmit side
  input wire logic txEvent,
  input wire logic txReady,
  output logic txValid,
  output logic [31:0] txData
);
  int rn = 0;
  int tn = 0;
  logic rxTook;
  logic txTook;
  initial begin
    rxReady = 1'b0;
    txValid = 1'b0;
    txData = 32'h0;
  end
  // count words on the edge, move outputs just after it
  always @(posedge clk) begin
    rxTook = rxReady && rxValid;
    txTook = txValid && txReady;
    rn = rn - int'(rxTook);
    tn = tn - int'(txTook);
    // a burst ending on this edge still sees its old request level
    if (!rxTook && rn == 0 && rxEvent) rn = int'(rxThr);
    if (!hold && !txTook && tn == 0 && (txEvent || prime != 8'h00)) begin
      tn = txEvent ? int'(txThr) : int'(prime);
    end
    if (!rst_n) begin
      rn = 0;
      tn = 0;
    end
    #1;
    // prompt service with random stalls on the receive side
    rxReady = rn > 0 && !hold && $urandom_range(3) != 0;
    txValid = tn > 0;
    if (txTook) txData = $urandom();
  end
endmodule : asf_dma_model
`default_nettype wire

// File: sim/tb_asf_audio_fifo_dma.sv
// bench: random pin and dma traffic checked against a queue model
`timescale 1ns/1ps
`default_nettype none
module tb_asf_audio_fifo_dma;
  import asf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic errClear = 1'b0;
  logic hold = 1'b0;
  logic ovf = 1'b0;
  logic udf = 1'b0;
  logic txRun = 1'b0;
  logic rxPinValid = 1'b0;
  logic txPinTake = 1'b0;
  logic [31:0] rxPinData = 32'h0;
  logic [7:0] prime = 8'h00;
  asf_ctrl_type rxCtl = '0;
  asf_ctrl_type txCtl = '0;
  logic rxPinReady, rxDmaValid, rxDmaReady, txDmaValid, txDmaReady;
  logic txPinValid, rxDmaEvent, txDmaEvent;
  logic [31:0] rxDmaData, txDmaData, txPinData;
  asf_stat_type rxStat, txStat;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int rxDens = 0;
  int thr[2] = '{1, 1};
  int pc[2] = '{0, 0};
  int dc[2] = '{0, 0};
  int pend[2] = '{0, 0};
  logic ev[2] = '{1'b0, 1'b0};
  logic flt[2] = '{1'b0, 1'b0};
  logic [31:0] rq[$];
  logic [31:0] tq[$];
  // thresholds up to 32 words, zero among them
  logic [7:0] tl[5] = '{8'h01, 8'h00, 8'h03, 8'h04, 8'h20};

  always #2.5 clk = ~clk;

  asf_audio_fifo_dma dut_u (.clk(clk), .rst_n(rst_n),
    .rxFifoControl(rxCtl), .txFifoControl(txCtl), .errClear(errClear),
    .rxPinValid(rxPinValid), .rxPinReady(rxPinReady),
    .rxPinData(rxPinData), .rxDmaValid(rxDmaValid),
    .rxDmaReady(rxDmaReady), .rxDmaData(rxDmaData),
    .txDmaValid(txDmaValid), .txDmaReady(txDmaReady),
    .txDmaData(txDmaData), .txPinTake(txPinTake),
    .txPinValid(txPinValid), .txPinData(txPinData),
    .rxDmaEvent(rxDmaEvent), .txDmaEvent(txDmaEvent),
    .rxStat(rxStat), .txStat(txStat));

  asf_dma_model dma_u (.clk(clk), .rst_n(rst_n), .rxThr(8'(thr[0])),
    .txThr(8'(thr[1])), .prime(prime), .hold(hold),
    .rxEvent(rxDmaEvent), .rxValid(rxDmaValid), .rxReady(rxDmaReady),
    .txEvent(txDmaEvent), .txReady(txDmaReady), .txValid(txDmaValid),
    .txData(txDmaData));

  task automatic chkBit(string nm, logic e, logic g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chkBit

  task automatic chkWord(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chkWord

  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // one direction's request counters, clear counted before set
  task automatic evt(int d, logic en, logic pm, logic dm);
    pc[d] = en ? pc[d] + int'(pm) : 0;
    dc[d] = en ? dc[d] + int'(dm) : 0;
    if (!en) pend[d] = 0;
    if (dc[d] == thr[d]) begin
      dc[d] = 0;
      if (pend[d] > 0) pend[d]--;
    end
    if (pc[d] == thr[d]) begin
      pc[d] = 0;
      pend[d]++;
    end
    ev[d] = pend[d] > 0;
  endtask : evt

  // compare at mid cycle, then advance the model over the next edge
  always @(negedge clk) begin
    logic en0, en1, ri, ro, ti, to;
    en0 = rxCtl.enable && rst_n;
    en1 = txCtl.enable && rst_n;
    chkBit("rxPinReady", en0 && rq.size() < 64, rxPinReady);
    chkBit("rxDmaValid", en0 && rq.size() > 0, rxDmaValid);
    chkBit("txDmaReady", en1 && tq.size() < 64, txDmaReady);
    chkBit("txPinValid", en1 && tq.size() > 0, txPinValid);
    if (en0 && rq.size() > 0) chkWord("rxDmaData", rq[0], rxDmaData);
    if (en1 && tq.size() > 0) chkWord("txPinData", tq[0], txPinData);
    chkBit("rxDmaEvent", ev[0], rxDmaEvent);
    chkBit("txDmaEvent", ev[1], txDmaEvent);
    chkWord("rxLevel", 32'(rq.size()), 32'(rxStat.level));
    chkWord("txLevel", 32'(tq.size()), 32'(txStat.level));
    chkBit("rxFault", flt[0], rxStat.fault);
    chkBit("txFault", flt[1], txStat.fault);
    ri = en0 && rxPinValid && rq.size() < 64;
    ro = en0 && rxDmaReady && rq.size() > 0;
    ti = en1 && txDmaValid && tq.size() < 64;
    to = en1 && txPinTake && tq.size() > 0;
    flt[0] = rst_n && ((rxPinValid && !ri) || (flt[0] && !errClear));
    flt[1] = rst_n && ((txPinTake && !to) || (flt[1] && !errClear));
    if (ro) void'(rq.pop_front());
    if (ri) rq.push_back(rxPinData);
    if (to) void'(tq.pop_front());
    if (ti) tq.push_back(txDmaData);
    if (!en0) rq.delete();
    if (!en1) tq.delete();
    evt(0, en0, ri, ro);
    evt(1, en1, to, ti);
  end

  // pin side traffic, changed just after each edge
  always @(posedge clk) begin
    #1;
    rxPinValid = rxCtl.enable && (ovf || (rq.size() < 64
      && $urandom_range(99) < rxDens));
    rxPinData = $urandom();
    txPinTake = udf || (txRun && tq.size() > 0 && $urandom_range(1) == 1);
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // drain the rx buffer, flush, reprogram both directions, then run traffic
  task automatic phase(logic [7:0] rt, logic [7:0] tt, int dens);
    asf_ctrl_type c;
    rxDens = 0;
    txRun <= 1'b0;
    repeat (100) @(posedge clk);
    rxCtl.enable <= 1'b0;
    txCtl.enable <= 1'b0;
    @(posedge clk);
    c = asf_ctrl_type'($urandom());
    c.threshold = rt;
    c.enable = 1'b1;
    rxCtl <= c;
    c = asf_ctrl_type'($urandom());
    c.threshold = tt;
    c.enable = 1'b1;
    txCtl <= c;
    thr[0] = (rt == 8'h00) ? 1 : int'(rt);
    thr[1] = (tt == 8'h00) ? 1 : int'(tt);
    @(posedge clk);
    prime <= 8'(thr[1]);
    rxDens = dens;
    txRun <= 1'b1;
    @(posedge clk);
    prime <= 8'h00;
    repeat (400) @(posedge clk);
  endtask : phase

  initial begin
    void'($urandom(32'hDB8C));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      phase(tl[i], tl[4 - i], (i % 2 == 0) ? 100 : 40);
    end
    // rx overflow with the dma held off, then a fault clear
    rxDens = 0;
    txRun <= 1'b0;
    hold <= 1'b1;
    ovf <= 1'b1;
    repeat (80) @(posedge clk);
    ovf <= 1'b0;
    @(posedge clk);
    errClear <= 1'b1;
    @(posedge clk);
    errClear <= 1'b0;
    hold <= 1'b0;
    rxDens = 60;
    repeat (200) @(posedge clk);
    // empty the tx buffer with new bursts held off, then underflow it
    rxDens = 0;
    hold <= 1'b1;
    txRun <= 1'b1;
    repeat (300) @(posedge clk);
    txRun <= 1'b0;
    txCtl.enable <= 1'b0;
    @(posedge clk);
    txCtl.threshold <= 8'h02;
    txCtl.enable <= 1'b1;
    thr[1] = 2;
    repeat (2) @(posedge clk);
    udf <= 1'b1;
    @(posedge clk);
    udf <= 1'b0;
    repeat (3) @(posedge clk);
    errClear <= 1'b1;
    @(posedge clk);
    errClear <= 1'b0;
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule : tb_asf_audio_fifo_dma
`default_nettype wire
